//--- pkg/mie_pkg.sv
/*
 * Shared constants and types for the instruction execution core.
 * Assumes a 16-bit program word, an 8-bit data path and an APB master.
 */
package mie_pkg;
	// ============================================================
	// APB register map
	localparam logic [7:0] APB_CTRL = 8'h00;
	localparam logic [7:0] APB_STAT = 8'h04;
	localparam logic [7:0] APB_PC = 8'h08;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_PAGE_LSB = 1;
	localparam int CTRL_PAGE_MSB = 2;
	// ============================================================
	// Data memory map
	localparam logic [7:0] SYS_BASE = 8'h80;
	localparam logic [4:0] BANK0_MOVE_HI = 5'b10000;
	localparam logic [7:0] REG_R = 8'h82;
	localparam logic [7:0] REG_Z = 8'h83;
	localparam logic [7:0] REG_Y = 8'h84;
	localparam logic [7:0] REG_PF = 8'h86;
	localparam int PF_Z = 0;
	localparam int PF_HC = 1;
	localparam int PF_C = 2;
	localparam int PF_PD = 6;
	localparam int PF_RA = 7;
	// ============================================================
	// Program word fields
	localparam int CLS_MSB = 15;
	localparam int CLS_LSB = 14;
	localparam int OP_MSB = 13;
	localparam int OP_LSB = 8;
	localparam int TGT_MSB = 13;
	localparam int BK_LSB = 12;
	localparam int BIT_MSB = 10;
	localparam int BIT_LSB = 8;
	localparam logic [1:0] CLS_OP = 2'b00;
	localparam logic [1:0] CLS_BIT_TEST = 2'b01;
	localparam logic [1:0] CLS_JUMP_OP = 2'b10;
	localparam logic [1:0] CLS_CALL = 2'b11;
	localparam logic [2:0] BANK0_MOVE_GRP = 3'b101;
	typedef enum logic [5:0] {
		OP_NOP = 6'h00, OP_MOV_AM = 6'h01, OP_MOV_MA = 6'h02, OP_MOV_AI = 6'h03,
		OP_XCH_AM = 6'h05, OP_BANK0_EXCHANGE = 6'h06, OP_ROM_TABLE_READ = 6'h07,
		OP_ADC_AM = 6'h08, OP_ADC_MA = 6'h09, OP_ADD_AM = 6'h0a, OP_ADD_MA = 6'h0b,
		OP_BANK0_MEM_ADD = 6'h0c, OP_ADD_AI = 6'h0d,
		OP_SUBTRACT_WITH_BORROW_AM = 6'h0e, OP_SUBTRACT_WITH_BORROW_MA = 6'h0f,
		OP_SUB_AM = 6'h10, OP_SUB_MA = 6'h11, OP_SUB_AI = 6'h12,
		OP_AND_AM = 6'h13, OP_AND_MA = 6'h14, OP_AND_AI = 6'h15,
		OP_OR_AM = 6'h16, OP_OR_MA = 6'h17, OP_OR_AI = 6'h18,
		OP_XOR_AM = 6'h19, OP_XOR_MA = 6'h1a, OP_XOR_AI = 6'h1b,
		OP_SWAP = 6'h1c, OP_NIBBLE_EXCHANGE_TO_MEM = 6'h1d,
		OP_COMPARE_SKIP_AI = 6'h1e, OP_COMPARE_SKIP_AM = 6'h1f,
		OP_INCREMENT_SKIP_TO_ACC = 6'h20, OP_INCREMENT_SKIP_TO_MEM = 6'h21,
		OP_DECREMENT_SKIP_TO_ACC = 6'h22, OP_DECREMENT_SKIP_TO_MEM = 6'h23,
		OP_RET = 6'h24, OP_INTERRUPT_RETURN = 6'h25, OP_PUSH = 6'h26, OP_POP = 6'h27
	} mie_op_t;
	typedef enum logic [1:0] {ST_RUN = 2'b00, ST_HOLD = 2'b01, ST_TABLE = 2'b10} mie_state_t;
	typedef struct packed {
		logic carry;
		logic half_carry_flag;
		logic zero;
	} mie_flags_t;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} mie_apb_req_t;
endpackage

//--- hdl/mie_core.sv
/*
 * Instruction execution core of an 8-bit controller with an APB control port.
 * Assumes an asynchronous program ROM: rom_data shows ROM[rom_addr] in the same cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module mie_core import mie_pkg::*; #(
	parameter int RAM_WORDS = 128,
	parameter int STACK_DEPTH = 8
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire mie_apb_req_t apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [15:0] rom_addr,
	input wire logic [15:0] rom_data,
	input wire logic [1:0] reset_cause
);
	localparam int RAM_AW = $clog2(RAM_WORDS);
	localparam int SP_W = $clog2(STACK_DEPTH);

	mie_state_t state;
	logic squash, run, gie;
	logic [1:0] page;
	logic [15:0] table_ret;
	logic [7:0] accumulator_reg, shadow_acc, reg_r, reg_y, reg_z;
	mie_flags_t flags, shadow_flags;
	logic reset_status_bit_a, power_down_status_bit;
	logic [1:0] rc_meta, rc_sync;
	logic [7:0] ram [RAM_WORDS];
	logic [15:0] stack [STACK_DEPTH];
	logic [SP_W-1:0] sp;

	// ============================================================
	// Decode and execute
	logic [1:0] cls;
	mie_op_t op;
	logic [7:0] opnd, mem_rd, processor_flag_reg, wr_addr;
	logic [7:0] ad_a, ad_b, res, acc_d;
	logic ad_cin, use_sum, zskip, xch;
	logic [8:0] sum;
	logic [4:0] lsum;
	logic carry_out, half_out;
	logic acc_we, mem_we, f_arith, f_cmp, f_z, skip, jump, ret, interrupt_return, push, pop, rom_table_read;
	logic exec_en, ram_wait;
	logic [15:0] target;

	assign cls = rom_data[CLS_MSB:CLS_LSB];
	assign op = mie_op_t'(rom_data[OP_MSB:OP_LSB]);
	assign opnd = rom_data[7:0];
	assign target = {page, rom_data[TGT_MSB:0]};
	assign exec_en = run && (state == ST_RUN) && !squash;
	assign carry_out = sum[8];
	assign half_out = lsum[4];
	assign ram_wait = mem_we && (wr_addr < SYS_BASE);

	always_comb begin
		processor_flag_reg = '0;
		processor_flag_reg[PF_Z] = flags.zero;
		processor_flag_reg[PF_HC] = flags.half_carry_flag;
		processor_flag_reg[PF_C] = flags.carry;
		processor_flag_reg[PF_PD] = power_down_status_bit;
		processor_flag_reg[PF_RA] = reset_status_bit_a;
		mem_rd = '0;
		if (opnd < SYS_BASE) begin
			mem_rd = ram[opnd[RAM_AW-1:0]];
		end else begin
			case (opnd)
				REG_R: mem_rd = reg_r;
				REG_Z: mem_rd = reg_z;
				REG_Y: mem_rd = reg_y;
				REG_PF: mem_rd = processor_flag_reg;
				default: mem_rd = '0;
			endcase
		end
	end

	always_comb begin
		ad_a = accumulator_reg;
		ad_b = mem_rd;
		ad_cin = 1'b0;
		use_sum = 1'b0;
		zskip = 1'b0;
		xch = 1'b0;
		res = '0;
		wr_addr = opnd;
		acc_we = 1'b0;
		mem_we = 1'b0;
		f_arith = 1'b0;
		f_cmp = 1'b0;
		f_z = 1'b0;
		skip = 1'b0;
		jump = 1'b0;
		ret = 1'b0;
		interrupt_return = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		rom_table_read = 1'b0;
		if (cls == CLS_OP && op[5:3] == BANK0_MOVE_GRP) begin
			// The target field is three bits wide, so only 0x80 to 0x87 is reachable.
			wr_addr = {BANK0_MOVE_HI, op[2:0]};
			res = opnd;
			mem_we = 1'b1;
		end else if (cls == CLS_OP) begin
			case (op)
				OP_NOP: res = '0;
				OP_MOV_AM: begin res = mem_rd; acc_we = 1'b1; f_z = 1'b1; end
				OP_MOV_MA: begin res = accumulator_reg; mem_we = 1'b1; end
				OP_MOV_AI: begin res = opnd; acc_we = 1'b1; end
				OP_XCH_AM: begin res = accumulator_reg; xch = 1'b1; end
				OP_BANK0_EXCHANGE: begin
					res = accumulator_reg;
					xch = (opnd < SYS_BASE);
				end
				OP_ROM_TABLE_READ: rom_table_read = 1'b1;
				OP_ADC_AM, OP_ADC_MA: begin
					ad_cin = flags.carry;
					use_sum = 1'b1;
					f_arith = 1'b1;
					acc_we = (op == OP_ADC_AM);
					mem_we = (op == OP_ADC_MA);
				end
				OP_ADD_AM, OP_ADD_MA, OP_BANK0_MEM_ADD, OP_ADD_AI: begin
					if (op == OP_ADD_AI) begin
						ad_b = opnd;
					end
					use_sum = 1'b1;
					f_arith = 1'b1;
					acc_we = (op == OP_ADD_AM) || (op == OP_ADD_AI);
					mem_we = (op == OP_ADD_MA) || (op == OP_BANK0_MEM_ADD);
				end
				OP_SUBTRACT_WITH_BORROW_AM, OP_SUBTRACT_WITH_BORROW_MA: begin
					// Borrow in is the inverted carry, so carry itself is the adder's carry in.
					ad_b = ~mem_rd;
					ad_cin = flags.carry;
					use_sum = 1'b1;
					f_arith = 1'b1;
					acc_we = (op == OP_SUBTRACT_WITH_BORROW_AM);
					mem_we = (op == OP_SUBTRACT_WITH_BORROW_MA);
				end
				OP_SUB_AM, OP_SUB_MA, OP_SUB_AI: begin
					ad_b = (op == OP_SUB_AI) ? ~opnd : ~mem_rd;
					ad_cin = 1'b1;
					use_sum = 1'b1;
					f_arith = 1'b1;
					acc_we = (op != OP_SUB_MA);
					mem_we = (op == OP_SUB_MA);
				end
				OP_AND_AM, OP_AND_MA: begin res = accumulator_reg & mem_rd; f_z = 1'b1; end
				OP_AND_AI: begin res = accumulator_reg & opnd; f_z = 1'b1; end
				OP_OR_AM, OP_OR_MA: begin res = accumulator_reg | mem_rd; f_z = 1'b1; end
				OP_OR_AI: begin res = accumulator_reg | opnd; f_z = 1'b1; end
				OP_XOR_AM, OP_XOR_MA: begin res = accumulator_reg ^ mem_rd; f_z = 1'b1; end
				OP_XOR_AI: begin res = accumulator_reg ^ opnd; f_z = 1'b1; end
				OP_SWAP: begin res = {mem_rd[3:0], mem_rd[7:4]}; acc_we = 1'b1; end
				OP_NIBBLE_EXCHANGE_TO_MEM: begin res = {mem_rd[3:0], mem_rd[7:4]}; mem_we = 1'b1; end
				OP_COMPARE_SKIP_AI, OP_COMPARE_SKIP_AM: begin
					ad_b = (op == OP_COMPARE_SKIP_AI) ? ~opnd : ~mem_rd;
					ad_cin = 1'b1;
					use_sum = 1'b1;
					f_cmp = 1'b1;
					zskip = 1'b1;
				end
				OP_INCREMENT_SKIP_TO_ACC, OP_INCREMENT_SKIP_TO_MEM,
				OP_DECREMENT_SKIP_TO_ACC, OP_DECREMENT_SKIP_TO_MEM: begin
					ad_a = mem_rd;
					ad_b = op[1] ? 8'hff : 8'h01;
					use_sum = 1'b1;
					zskip = 1'b1;
					acc_we = !op[0];
					mem_we = op[0];
				end
				OP_RET: ret = 1'b1;
				OP_INTERRUPT_RETURN: begin ret = 1'b1; interrupt_return = 1'b1; end
				OP_PUSH: push = 1'b1;
				OP_POP: pop = 1'b1;
				default: res = '0;
			endcase
			if (f_z && !acc_we) begin
				acc_we = !(op inside {OP_AND_MA, OP_OR_MA, OP_XOR_MA});
				mem_we = !acc_we;
			end
		end else if (cls == CLS_BIT_TEST) begin
			skip = (mem_rd[rom_data[BIT_MSB:BIT_LSB]] == rom_data[BK_LSB]);
		end else begin
			jump = 1'b1;
		end
		sum = {1'b0, ad_a} + {1'b0, ad_b} + {8'h00, ad_cin};
		lsum = {1'b0, ad_a[3:0]} + {1'b0, ad_b[3:0]} + {4'h0, ad_cin};
		if (use_sum) begin
			res = sum[7:0];
		end
		if (zskip) begin
			skip = (res == 8'h00);
		end
		if (xch) begin
			acc_we = 1'b1;
			mem_we = 1'b1;
		end
		acc_d = xch ? mem_rd : res;
		if (f_cmp) begin
			acc_we = 1'b0;
		end
	end

	// ============================================================
	// Program counter, skips and wait states
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state <= ST_RUN;
			squash <= 1'b0;
			rom_addr <= '0;
			table_ret <= '0;
		end else begin
			// A hold or table cycle under way finishes even when run drops, so nothing is cut.
			unique case (state)
				ST_RUN: if (run) begin
					if (squash) begin
						rom_addr <= rom_addr + 16'h1;
						squash <= 1'b0;
					end else if (jump) begin
						rom_addr <= target;
						state <= ST_HOLD;
					end else if (ret) begin
						rom_addr <= stack[sp - 1'b1];
						state <= ST_HOLD;
					end else if (rom_table_read) begin
						table_ret <= rom_addr + 16'h1;
						rom_addr <= {reg_y, reg_z};
						state <= ST_TABLE;
					end else begin
						rom_addr <= rom_addr + 16'h1;
						squash <= skip;
						if (ram_wait) begin
							state <= ST_HOLD;
						end
					end
				end
				ST_HOLD: state <= ST_RUN;
				ST_TABLE: begin
					rom_addr <= table_ret;
					state <= ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sp <= '0;
		end else if (exec_en && jump && cls == CLS_CALL) begin
			stack[sp] <= rom_addr + 16'h1;
			sp <= sp + 1'b1;
		end else if (exec_en && ret) begin
			sp <= sp - 1'b1;
		end
	end

	// ============================================================
	// Accumulator, flags and shadow buffers
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			accumulator_reg <= '0;
			shadow_acc <= '0;
			shadow_flags <= '0;
		end else if (state == ST_TABLE) begin
			accumulator_reg <= rom_data[7:0];
		end else if (exec_en) begin
			if (push) begin
				shadow_acc <= accumulator_reg;
				shadow_flags <= flags;
			end
			if (pop) begin
				accumulator_reg <= shadow_acc;
			end else if (acc_we) begin
				accumulator_reg <= acc_d;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			flags <= '0;
		end else if (exec_en) begin
			if (pop) begin
				flags <= shadow_flags;
			end else if (f_arith) begin
				flags <= '{carry: carry_out, half_carry_flag: half_out, zero: res == 8'h00};
			end else if (f_cmp) begin
				flags.carry <= carry_out;
				flags.zero <= (res == 8'h00);
			end else if (f_z) begin
				flags.zero <= (res == 8'h00);
			end else if (mem_we && wr_addr == REG_PF) begin
				flags <= '{carry: res[PF_C], half_carry_flag: res[PF_HC], zero: res[PF_Z]};
			end
		end
	end

	// The status bits only follow the reset cause input and are never written by code.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rc_meta <= '0;
			rc_sync <= '0;
			reset_status_bit_a <= 1'b0;
			power_down_status_bit <= 1'b0;
		end else begin
			rc_meta <= reset_cause;
			rc_sync <= rc_meta;
			reset_status_bit_a <= rc_sync[1];
			power_down_status_bit <= rc_sync[0];
		end
	end

	// ============================================================
	// Data memory and system registers
	always_ff @(posedge core_clk) begin
		if (exec_en && mem_we && wr_addr < SYS_BASE) begin
			ram[wr_addr[RAM_AW-1:0]] <= res;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			reg_r <= '0;
			reg_y <= '0;
			reg_z <= '0;
		end else if (state == ST_TABLE) begin
			reg_r <= rom_data[15:8];
		end else if (exec_en && mem_we) begin
			if (wr_addr == REG_R) begin
				reg_r <= res;
			end
			if (wr_addr == REG_Y) begin
				reg_y <= res;
			end
			if (wr_addr == REG_Z) begin
				reg_z <= res;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			gie <= 1'b0;
		end else if (exec_en && interrupt_return) begin
			gie <= 1'b1;
		end
	end

	// ============================================================
	// APB slave
	logic acc_ph;
	assign acc_ph = apb_req.psel && apb_req.penable;

	// The answer is registered, so every transfer takes two access cycles.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end else begin
			pready <= acc_ph && !pready;
			if (acc_ph && !pready) begin
				pslverr <= 1'b0;
				case (apb_req.paddr)
					APB_CTRL: prdata <= {29'h0, page, run};
					APB_STAT: prdata <= {15'h0, gie, processor_flag_reg, accumulator_reg};
					APB_PC: prdata <= {16'h0, rom_addr};
					default: begin
						prdata <= '0;
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			run <= 1'b0;
			page <= '0;
		end else if (acc_ph && pready && apb_req.pwrite && apb_req.paddr == APB_CTRL) begin
			run <= apb_req.pwdata[CTRL_RUN];
			page <= apb_req.pwdata[CTRL_PAGE_MSB:CTRL_PAGE_LSB];
		end
	end

	// ============================================================
	// Assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	property p_add_flags;
		(exec_en && cls == CLS_OP && op == OP_ADD_AM && accumulator_reg == 8'h0f && mem_rd == 8'hf1)
			|=> flags.carry && flags.zero && flags.half_carry_flag && accumulator_reg == 8'h00;
	endproperty
	a_add_flags: assert property (p_add_flags) else $error("add flags wrong");
	property p_adc_carry;
		(exec_en && cls == CLS_OP && op == OP_ADC_AM && flags.carry && mem_rd == 8'h00)
			|=> accumulator_reg == $past(accumulator_reg) + 8'h01;
	endproperty
	a_adc_carry: assert property (p_adc_carry) else $error("carry not added");
	property p_sub_borrow;
		(exec_en && cls == CLS_OP && op == OP_SUB_AM) |=> flags.carry == ($past(res) <= $past(ad_a));
	endproperty
	a_sub_borrow: assert property (p_sub_borrow) else $error("borrow flag wrong");
	property p_sbc;
		(exec_en && cls == CLS_OP && op == OP_SUBTRACT_WITH_BORROW_AM && !flags.carry
			&& accumulator_reg == mem_rd) |=> accumulator_reg == 8'hff && !flags.carry;
	endproperty
	a_sbc: assert property (p_sbc) else $error("borrow not subtracted");
	property p_logic_keep;
		(exec_en && f_z) |=> $stable(flags.carry) && $stable(flags.half_carry_flag);
	endproperty
	a_logic_keep: assert property (p_logic_keep) else $error("logic op changed carry");
	property p_exchange_guard;
		(exec_en && cls == CLS_OP && op == OP_BANK0_EXCHANGE && opnd >= SYS_BASE) |-> !mem_we && !acc_we;
	endproperty
	a_exchange_guard: assert property (p_exchange_guard) else $error("exchange on sysreg");
	property p_table;
		logic [15:0] tw;
		(exec_en && rom_table_read) ##1 (state == ST_TABLE, tw = rom_data)
			|=> state == ST_RUN && accumulator_reg == tw[7:0] && reg_r == tw[15:8];
	endproperty
	a_table: assert property (p_table) else $error("table read wrong");
	property p_inc_skip;
		(exec_en && cls == CLS_OP && op == OP_INCREMENT_SKIP_TO_ACC)
			|=> $stable(flags) && squash == (accumulator_reg == 8'h00);
	endproperty
	a_inc_skip: assert property (p_inc_skip) else $error("increment skip wrong");
	property p_jump;
		logic [15:0] t;
		(exec_en && jump, t = target) |=> state == ST_HOLD && rom_addr == t ##1 state == ST_RUN;
	endproperty
	a_jump: assert property (p_jump) else $error("jump target or timing wrong");
	property p_interrupt_return;
		(exec_en && interrupt_return) |=> gie && state == ST_HOLD;
	endproperty
	a_interrupt_return: assert property (p_interrupt_return) else $error("interrupt enable not set");
	property p_ram_wait;
		(exec_en && ram_wait && !skip) |=> state == ST_HOLD ##1 state == ST_RUN && !squash;
	endproperty
	a_ram_wait: assert property (p_ram_wait) else $error("missing ram wait");
	property p_squash;
		(run && state == ST_RUN && squash) |=> !squash && rom_addr == $past(rom_addr) + 16'h1;
	endproperty
	a_squash: assert property (p_squash) else $error("skip discard wrong");

	c_jump: cover property (exec_en && jump ##2 exec_en);
	c_skip: cover property (exec_en && skip ##1 squash);
	c_table: cover property (exec_en && rom_table_read ##1 state == ST_TABLE);
	c_ram_wait: cover property (exec_en && ram_wait ##1 state == ST_HOLD);
endmodule
`default_nettype wire

//--- verif/mie_rom_model.sv
/*
 * Program ROM model standing on the far side of the execution core.
 * Assumes the bench fills mem only while the core is held in reset or stopped.
 */
`timescale 1ns/1ps
`default_nettype none
module mie_rom_model import mie_pkg::*; (
	input wire logic [15:0] rom_addr,
	output logic [15:0] rom_data
);
	// ============================================================
	// Asynchronous array
	// Only the low byte decodes, so every page aliases onto one small array.
	logic [15:0] mem [256];
	initial begin
		foreach (mem[i]) mem[i] = 16'h0000;
	end
	assign rom_data = mem[rom_addr[7:0]];
endmodule
`default_nettype wire

//--- verif/test_mie_core.sv
/*
 * Self-checking bench for mie_core: APB register access and short ROM programs.
 * Assumes a same-cycle ROM and that the core only runs while the run bit is set.
 */
`timescale 1ns/1ps
`default_nettype none
module test_mie_core import mie_pkg::*; ();
	// ============================================================
	// Signals
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	mie_apb_req_t apb_req = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [15:0] rom_addr;
	logic [15:0] rom_data;
	logic [1:0] reset_cause = 2'b00;
	int fail_count = 0;
	int n_compared = 0;
	int cyc = 0;
	int t1 = -1;
	int exp_cyc = 0;
	logic watch = 1'b0;
	logic halted = 1'b0;
	logic [15:0] halt_addr = 16'h0000;
	logic [32:0] exp_q[$];
	logic [15:0] prog[$];
	logic [1:0] rc;
	logic [7:0] a;
	logic [7:0] m;
	logic [2:0] f;
	logic [15:0] d;
	logic [1:0] pg;
	logic [10:0] r;
	mie_op_t ops[7] = '{OP_ADD_AM, OP_ADC_AM, OP_SUB_AM, OP_SUBTRACT_WITH_BORROW_AM,
		OP_AND_AM, OP_OR_AM, OP_XOR_AM};

	always #50 core_clk = ~core_clk;

	mie_core mie_core_i (.core_clk(core_clk), .sys_rst(sys_rst), .apb_req(apb_req),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rom_addr(rom_addr),
		.rom_data(rom_data), .reset_cause(reset_cause));
	mie_rom_model mie_rom_model_i (.rom_addr(rom_addr), .rom_data(rom_data));

	// ============================================================
	// Checking and reporting
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_compared++;
		if (seen !== want) begin
			fail_count++;
			$display("wrong value at %0t ns: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic test_done();
		$display("compared %0d, mismatched %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// The watcher pairs each finished transfer with the oldest note and times each program.
	always @(posedge core_clk) begin
		logic [32:0] e;
		if (apb_req.psel && apb_req.penable && pready === 1'b1 && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			check({31'h0, pslverr}, {31'h0, e[32]});
			if (!apb_req.pwrite) check(prdata, e[31:0]);
		end
		if (watch && rom_addr === 16'h0001 && t1 < 0) t1 = cyc;
		if (watch && rom_addr === halt_addr && !halted && t1 >= 0) begin
			halted = 1'b1;
			check(32'(cyc - t1), 32'(exp_cyc));
		end
		cyc++;
	end

	// ============================================================
	// APB master
	task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] dt);
		int n;
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: ad, pwdata: dt};
		@(posedge core_clk);
		apb_req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		apb_req <= '0;
		if (n >= 20) begin
			fail_count++;
			test_done();
		end
		@(posedge core_clk);
	endtask

	task automatic rd(input logic [7:0] ad, input logic [31:0] want, input logic err);
		exp_q.push_back({err, want});
		apb(1'b0, ad, 32'h0);
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] dt, input logic err);
		exp_q.push_back({err, 32'h0});
		apb(1'b1, ad, dt);
	endtask

	// ============================================================
	// Programs and expected results
	function automatic logic [15:0] w(input logic [5:0] op, input logic [7:0] arg);
		return {2'b00, op, arg};
	endfunction

	function automatic logic [31:0] stat(input logic [10:0] v, input logic ie);
		return {15'h0, ie, rc, 3'b000, v};
	endfunction

	function automatic logic [10:0] alu(input mie_op_t op, input logic [7:0] x, input logic [7:0] y,
		input logic [2:0] fl);
		logic [8:0] s;
		logic [4:0] h;
		logic k;
		logic [7:0] q;
		logic c;
		logic hc;
		c = fl[2];
		hc = fl[1];
		k = (op == OP_ADC_AM) ? fl[2] : (op == OP_SUBTRACT_WITH_BORROW_AM) ? !fl[2] : 1'b0;
		case (op)
			OP_ADD_AM, OP_ADC_AM: begin
				s = {1'b0, x} + {1'b0, y} + {8'h00, k};
				h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, k};
				{c, hc, q} = {s[8], h[4], s[7:0]};
			end
			OP_SUB_AM, OP_SUBTRACT_WITH_BORROW_AM: begin
				s = {1'b0, x} - {1'b0, y} - {8'h00, k};
				h = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, k};
				{c, hc, q} = {!s[8], !h[4], s[7:0]};
			end
			OP_AND_AM: q = x & y;
			OP_OR_AM: q = x | y;
			default: q = x ^ y;
		endcase
		return {c, hc, q == 8'h00, q};
	endfunction

	task automatic put(input logic [15:0] word, input int cost);
		prog.push_back(word);
		exp_cyc += cost;
	endtask

	task automatic start();
		sys_rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		prog.delete();
		exp_cyc = 0;
		put(w(OP_NOP, 8'h00), 1);
	endtask

	// A trailing jump to itself parks the core so the finish can be seen on rom_addr.
	task automatic run(input logic [1:0] page, input int extra);
		int n;
		int h;
		h = prog.size() + 1;
		put(w(OP_NOP, 8'h00), extra);
		prog.push_back({2'b10, 14'(h)});
		foreach (prog[i]) mie_rom_model_i.mem[i] = prog[i];
		halt_addr = {page, 14'(h)};
		t1 = -1;
		halted = 1'b0;
		watch = 1'b1;
		wr(APB_CTRL, {29'h0, page, 1'b1}, 1'b0);
		n = 0;
		while (!halted && n < 500) begin
			@(posedge core_clk);
			n++;
		end
		if (!halted) begin
			fail_count++;
			test_done();
		end
		watch = 1'b0;
		wr(APB_CTRL, {29'h0, page, 1'b0}, 1'b0);
	endtask

	// ============================================================
	// Main sequence
	initial begin
		rc = 2'($urandom(32'hb7617787));
		rc = 2'($urandom());
		reset_cause <= rc;
		repeat (20) @(posedge core_clk);
		sys_rst <= 1'b0;
		// The reset status bits need three edges to come through their synchroniser.
		repeat (3) @(posedge core_clk);
		rd(APB_STAT, stat(11'h0, 1'b0), 1'b0);
		rd(APB_PC, 32'h0, 1'b0);
		wr(APB_STAT, 32'hffff_ffff, 1'b0);
		rd(APB_STAT, stat(11'h0, 1'b0), 1'b0);
		wr(APB_CTRL, 32'h0000_0006, 1'b0);
		rd(APB_CTRL, 32'h0000_0006, 1'b0);
		rd(8'h0c, 32'h0, 1'b1);
		$display("test registers done");
		foreach (ops[i]) begin
			a = 8'($urandom());
			m = 8'($urandom());
			f = 3'($urandom());
			start();
			put(w(OP_MOV_AI, m), 1);
			put(w(OP_MOV_MA, 8'h10), 2);
			put(w(6'h2e, {5'h00, f}), 1);
			put(w(OP_MOV_AI, a), 1);
			put(w(ops[i], 8'h10), 1);
			run(2'b00, 0);
			rd(APB_STAT, stat(alu(ops[i], a, m, f), 1'b0), 1'b0);
		end
		$display("test arithmetic and logic done");
		start();
		put(w(OP_MOV_AI, m), 1);
		put(w(OP_MOV_MA, 8'h11), 2);
		put(w(OP_MOV_AI, a), 1);
		put(w(OP_BANK0_MEM_ADD, 8'h11), 2);
		put(w(OP_MOV_MA, 8'h82), 1);
		put(w(OP_SWAP, 8'h11), 1);
		run(2'b00, 0);
		r = alu(OP_ADD_AM, a, m, 3'b000);
		rd(APB_STAT, stat({r[10:8], r[3:0], r[7:4]}, 1'b0), 1'b0);
		$display("test memory add and swap done");
		d = 16'($urandom());
		mie_rom_model_i.mem[8'h40] = d;
		start();
		put(w(6'h2b, 8'h40), 1);
		put(w(6'h2c, 8'h00), 1);
		put(w(OP_ROM_TABLE_READ, 8'h00), 2);
		put(w(OP_BANK0_EXCHANGE, 8'h82), 1);
		put(w(OP_SUB_AM, 8'h82), 1);
		run(2'b00, 0);
		rd(APB_STAT, stat(alu(OP_SUB_AM, d[7:0], d[15:8], 3'b000), 1'b0), 1'b0);
		$display("test table read done");
		a = 8'($urandom_range(254));
		start();
		put(w(OP_MOV_AI, 8'hff), 1);
		put(w(OP_MOV_MA, 8'h13), 2);
		put(w(OP_INCREMENT_SKIP_TO_MEM, 8'h13), 3);
		put(w(OP_MOV_AI, 8'h55), 0);
		put(w(OP_INCREMENT_SKIP_TO_ACC, 8'h13), 1);
		put(w(OP_DECREMENT_SKIP_TO_ACC, 8'h13), 1);
		put(w(OP_DECREMENT_SKIP_TO_MEM, 8'h13), 2);
		put({2'b01, 1'b0, 1'b1, 1'b0, 3'd0, 8'h13}, 2);
		put(w(OP_MOV_AI, 8'h55), 0);
		put({2'b01, 1'b0, 1'b0, 1'b0, 3'd0, 8'h13}, 1);
		put(w(OP_MOV_AI, a), 1);
		put(w(OP_COMPARE_SKIP_AI, a), 2);
		put(w(OP_MOV_AI, 8'h55), 0);
		put(w(OP_COMPARE_SKIP_AI, a + 8'h01), 1);
		run(2'b00, 0);
		rd(APB_STAT, stat({3'b000, a}, 1'b0), 1'b0);
		$display("test skips done");
		pg = 2'($urandom_range(3, 1));
		mie_rom_model_i.mem[8'h30] = w(OP_INTERRUPT_RETURN, 8'h00);
		mie_rom_model_i.mem[8'h32] = w(OP_RET, 8'h00);
		start();
		put(w(OP_MOV_AI, a), 1);
		put(w(6'h2e, 8'h05), 1);
		put(w(OP_PUSH, 8'h00), 1);
		put(w(OP_MOV_AI, m), 1);
		put(w(6'h2e, 8'h02), 1);
		put({2'b11, 14'h0030}, 4);
		put({2'b11, 14'h0032}, 4);
		put(w(OP_POP, 8'h00), 1);
		run(pg, 1);
		rd(APB_PC, {16'h0, pg, 14'd10}, 1'b0);
		rd(APB_STAT, stat({3'b101, a}, 1'b1), 1'b0);
		$display("test calls and returns done");
		test_done();
	end
endmodule
`default_nettype wire
